// file: pccr_counter_capture_regs.sv
// APB register block for the array counter and five capture/compare modules
//
// Implementation choice: the APB interface to the registers.
`default_nettype none
`include "pccr_cfg.svh"

// Function
// R1 - Counter bits 15 to 8 are a byte register at index 0xFA.
// R2 - Reading the counter high byte returns the snapshot latch, not the live byte.
// R3 - The snapshot latch loads the counter upper byte only when the low byte is read.
// R4 - Writes to the counter high byte are ignored while the watchdog enable is 1.
// R5 - Capture low bytes of modules 0 and 1 sit at indices 0xFB and 0xE9.
// R6 - Capture low bytes of modules 2, 3 and 4 sit at 0xEB, 0xED and 0xFD.
// R7 - A write to a capture low byte clears that module's comparator enable.
// R8 - Capture high bytes of modules 0 and 1 sit at indices 0xFC and 0xEA.
// R9 - Capture high bytes of modules 2, 3 and 4 sit at 0xEC, 0xEE and 0xFE.
// R10 - A write to a capture high byte sets that module's comparator enable.
// R11 - The counter high byte is reachable without any page selection.
// R12 - Counter bits 7 to 0 are a byte register at 0xF9 whose read loads the snapshot.
// R13 - An enabled comparator compares the counter with the module's capture value.
// R14 - Writes to the counter low byte are ignored while the watchdog enable is 1.
// R15 - Counter, capture bytes and snapshot latch clear to zero on reset.
// R16 - The snapshot keeps its value over any number of high reads until a low read.
module pccr_counter_capture_regs
	import pccr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [4:0]       matchOut,
	output logic [4:0]       compEnable,
	output logic             watchdogEnable
);

	typedef struct packed {
		pccr_sel_t  sel;
		logic [4:0] modMask;
	} pccr_dec_t;

	// R1 R5 R6 R8 R9 R11 R12 - flat decode, no page
	function automatic pccr_dec_t decodeAddr(input logic [11:0] addr);
		pccr_dec_t d;
		d.sel     = SEL_NONE;
		d.modMask = 5'h00;
		if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) begin
			unique case (addr[9:2])
				`PCCR_IDX_CNT_LO: d.sel = SEL_CNT_LO;
				`PCCR_IDX_CNT_HI: d.sel = SEL_CNT_HI;
				`PCCR_IDX_CTRL:   d.sel = SEL_CTRL;
				`PCCR_IDX_STAT:   d.sel = SEL_STAT;
				`PCCR_IDX_CAP_LO0: begin
					d.sel = SEL_CAP_LO;
					d.modMask = 5'h01;
				end
				`PCCR_IDX_CAP_LO1: begin
					d.sel = SEL_CAP_LO;
					d.modMask = 5'h02;
				end
				`PCCR_IDX_CAP_LO2: begin
					d.sel = SEL_CAP_LO;
					d.modMask = 5'h04;
				end
				`PCCR_IDX_CAP_LO3: begin
					d.sel = SEL_CAP_LO;
					d.modMask = 5'h08;
				end
				`PCCR_IDX_CAP_LO4: begin
					d.sel = SEL_CAP_LO;
					d.modMask = 5'h10;
				end
				`PCCR_IDX_CAP_HI0: begin
					d.sel = SEL_CAP_HI;
					d.modMask = 5'h01;
				end
				`PCCR_IDX_CAP_HI1: begin
					d.sel = SEL_CAP_HI;
					d.modMask = 5'h02;
				end
				`PCCR_IDX_CAP_HI2: begin
					d.sel = SEL_CAP_HI;
					d.modMask = 5'h04;
				end
				`PCCR_IDX_CAP_HI3: begin
					d.sel = SEL_CAP_HI;
					d.modMask = 5'h08;
				end
				`PCCR_IDX_CAP_HI4: begin
					d.sel = SEL_CAP_HI;
					d.modMask = 5'h10;
				end
				default: d.sel = SEL_NONE;
			endcase
		end
		return d;
	endfunction

	// Aligned, in-range hit on one register index
	function automatic logic addrHits(input logic [11:0] addr, input logic [7:0] idx);
		return addr[1:0] == 2'h0 && addr[11:10] == 2'h0 && addr[9:2] == idx;
	endfunction

	pccr_dec_t   dec;
	logic        accPhase;
	logic        rdFire;
	logic        wrFire;
	logic        wrByte;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        wdt_q;
	logic        run_q;
	logic [15:0] countValue;
	logic [7:0]  snapshot;
	logic [15:0] capValue [`PCCR_NUM_MODS];
	logic [4:0]  capEn;
	logic [4:0]  capMatch;
	pccr_cntwr_t cntCmd;
	pccr_capwr_t capCmd [`PCCR_NUM_MODS];
	logic [7:0]  capLoRd;
	logic [7:0]  capHiRd;

	assign dec      = decodeAddr(paddr);
	assign accPhase = psel && penable;
	// One wait state: read data sampled on the first access edge, write data on the second
	assign rdFire   = accPhase && !pready_q && !pwrite;
	assign wrFire   = accPhase && pready_q && pwrite;
	// Only byte lane 0 carries write data
	assign wrByte   = wrFire && pstrb[0];

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= accPhase && !pready_q;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= accPhase && !pready_q && (dec.sel == SEL_NONE);
		end
	end

	// Software control bits; not locked by the watchdog
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wdt_q <= 1'b0;
			run_q <= 1'b0;
		end else if (wrByte && dec.sel == SEL_CTRL) begin
			wdt_q <= pwdata[`PCCR_CTRL_WDT_BIT];
			run_q <= pwdata[`PCCR_CTRL_RUN_BIT];
		end
	end

	// R3 R12 - snapshot on low read
	always_comb begin
		cntCmd.wrLow    = wrByte && dec.sel == SEL_CNT_LO;
		cntCmd.wrHigh   = wrByte && dec.sel == SEL_CNT_HI;
		cntCmd.snapLoad = rdFire && dec.sel == SEL_CNT_LO;
		cntCmd.data     = pwdata[7:0];
	end

	// R4 R14 - lock applied inside counter
	pccr_counter u_counter (
		.clk_sys        (clk_sys),
		.reset_n        (reset_n),
		.runEn          (run_q),
		.watchdogEnable (wdt_q),
		.cmd            (cntCmd),
		.countValue     (countValue),
		.snapshot       (snapshot)
	);

	genvar gi;
	generate
		for (gi = 0; gi < `PCCR_NUM_MODS; gi++) begin : g_mod
			// R7 R10 - per-module write strobes
			always_comb begin
				capCmd[gi].wrLow  = wrByte && dec.sel == SEL_CAP_LO && dec.modMask[gi];
				capCmd[gi].wrHigh = wrByte && dec.sel == SEL_CAP_HI && dec.modMask[gi];
				capCmd[gi].data   = pwdata[7:0];
			end
			pccr_capture u_capture (
				.clk_sys    (clk_sys),
				.reset_n    (reset_n),
				.cmd        (capCmd[gi]),
				.countValue (countValue),
				.value      (capValue[gi]),
				.compEnable (capEn[gi]),
				.matchOut   (capMatch[gi])
			);
		end
	endgenerate

	always_comb begin
		capLoRd = 8'h00;
		capHiRd = 8'h00;
		for (int i = 0; i < `PCCR_NUM_MODS; i++) begin
			if (dec.modMask[i]) begin
				capLoRd = capValue[i][7:0];
				capHiRd = capValue[i][15:8];
			end
		end
	end

	// R2 - high byte reads the latch
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (rdFire) begin
			unique case (dec.sel)
				SEL_CNT_LO: prdata_q <= {24'h00_0000, countValue[7:0]};
				SEL_CNT_HI: prdata_q <= {24'h00_0000, snapshot};
				SEL_CAP_LO: prdata_q <= {24'h00_0000, capLoRd};
				SEL_CAP_HI: prdata_q <= {24'h00_0000, capHiRd};
				SEL_CTRL:   prdata_q <= {30'h0000_0000, run_q, wdt_q};
				SEL_STAT:   prdata_q <= {19'h0_0000, capMatch, 3'h0, capEn};
				SEL_NONE:   prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign matchOut       = capMatch;
	assign compEnable     = capEn;
	assign watchdogEnable = wdt_q;

	chk_ready_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pready |=> !pready)
		else $error("pready held longer than one cycle");

	chk_unmapped_err: assert property (@(posedge clk_sys) disable iff (!reset_n)
		accPhase && !pready_q && dec.sel == SEL_NONE |=> pready && pslverr && (prdata == 32'h0 || $past(pwrite)))
		else $error("unmapped access not flagged");

	chk_high_reads_snap: assert property (@(posedge clk_sys) disable iff (!reset_n) // R2
		rdFire && dec.sel == SEL_CNT_HI |=> prdata[7:0] == $past(snapshot) && pready && !pslverr)
		else $error("high byte read did not return snapshot");

	chk_page_free: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
		rdFire && (dec.sel == SEL_CNT_HI || dec.sel == SEL_CNT_LO) |=> !pslverr && pready)
		else $error("counter byte not reachable");

	chk_snap_load: assert property (@(posedge clk_sys) disable iff (!reset_n) // R3
		rdFire && dec.sel == SEL_CNT_LO |=> snapshot == $past(countValue[15:8]))
		else $error("snapshot not loaded on low read");

	chk_snap_hold: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
		!(rdFire && dec.sel == SEL_CNT_LO) |=> $stable(snapshot))
		else $error("snapshot changed without low read");

	chk_wdt_lock_hi: assert property (@(posedge clk_sys) disable iff (!reset_n) // R4
		wrByte && dec.sel == SEL_CNT_HI && wdt_q && !run_q |=> $stable(countValue))
		else $error("high byte written under watchdog");

	chk_wdt_lock_lo: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14
		wrByte && dec.sel == SEL_CNT_LO && wdt_q && !run_q |=> $stable(countValue))
		else $error("low byte written under watchdog");

	chk_low_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // R12
		wrByte && dec.sel == SEL_CNT_LO && !wdt_q |=> countValue[7:0] == $past(pwdata[7:0]))
		else $error("low byte write lost");

	chk_low_clears_en: assert property (@(posedge clk_sys) disable iff (!reset_n) // R7
		wrByte && dec.sel == SEL_CAP_LO |=> (compEnable & $past(dec.modMask)) == 5'h00)
		else $error("comparator enable not cleared");

	chk_high_sets_en: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
		wrByte && dec.sel == SEL_CAP_HI |=> (compEnable & $past(dec.modMask)) == $past(dec.modMask))
		else $error("comparator enable not set");

	chk_cap_lo_map: assert property (@(posedge clk_sys) disable iff (!reset_n) // R6
		wrByte && paddr[9:2] == `PCCR_IDX_CAP_LO4 && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0
		|=> capValue[4][7:0] == $past(pwdata[7:0]))
		else $error("module 4 low byte misplaced");

	chk_cap_hi_map: assert property (@(posedge clk_sys) disable iff (!reset_n) // R8
		wrByte && paddr[9:2] == `PCCR_IDX_CAP_HI1 && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0
		|=> capValue[1][15:8] == $past(pwdata[7:0]))
		else $error("module 1 high byte misplaced");

	chk_match_needs_en: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
		matchOut[0] |-> $past(compEnable[0]) && $past(countValue) == $past(capValue[0]))
		else $error("match without enabled equal compare");

	chk_high_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // R1
		wrByte && dec.sel == SEL_CNT_HI && !wdt_q |=> countValue[15:8] == $past(pwdata[7:0]))
		else $error("high byte write lost");

	chk_low_keeps_high: assert property (@(posedge clk_sys) disable iff (!reset_n) // R12
		wrByte && dec.sel == SEL_CNT_LO && !wdt_q |=> countValue[15:8] == $past(countValue[15:8]))
		else $error("low byte write disturbed high byte");

	chk_snap_read_keep: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
		rdFire && dec.sel == SEL_CNT_HI |=> $stable(snapshot))
		else $error("high byte read moved snapshot");

	// Two low samples in a row, so the very first edge never judges unreset flops
	chk_reset_clear: assert property (@(posedge clk_sys) // R15
		!reset_n && !$past(reset_n) |-> countValue == 16'h0000 && snapshot == 8'h00 && capEn == 5'h00 && !wdt_q)
		else $error("state not cleared by reset");

	chk_cap_lo0_map: assert property (@(posedge clk_sys) disable iff (!reset_n) // R5
		wrByte && addrHits(paddr, `PCCR_IDX_CAP_LO0) |=> capValue[0][7:0] == $past(pwdata[7:0]))
		else $error("module 0 low byte misplaced");

	chk_cap_hi0_map: assert property (@(posedge clk_sys) disable iff (!reset_n) // R8
		wrByte && addrHits(paddr, `PCCR_IDX_CAP_HI0) |=> capValue[0][15:8] == $past(pwdata[7:0]))
		else $error("module 0 high byte misplaced");

	chk_cap_lo3_map: assert property (@(posedge clk_sys) disable iff (!reset_n) // R6
		wrByte && addrHits(paddr, `PCCR_IDX_CAP_LO3) |=> capValue[3][7:0] == $past(pwdata[7:0]))
		else $error("module 3 low byte misplaced");

	chk_cap_hi4_map: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
		wrByte && addrHits(paddr, `PCCR_IDX_CAP_HI4) |=> capValue[4][15:8] == $past(pwdata[7:0]))
		else $error("module 4 high byte misplaced");

	chk_strobe_off: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
		wrFire && !pstrb[0] |=> $stable(capEn) && $stable(wdt_q))
		else $error("masked write had an effect");

	chk_no_match_off: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
		!compEnable[0] |=> !matchOut[0])
		else $error("match while comparator disabled");

	chk_ready_latency: assert property (@(posedge clk_sys) disable iff (!reset_n)
		accPhase && !pready_q |=> pready)
		else $error("pready not in second access cycle");

	chk_err_with_ready: assert property (@(posedge clk_sys) disable iff (!reset_n)
		pslverr |-> pready)
		else $error("pslverr without pready");

	chk_unmapped_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wrFire && dec.sel == SEL_NONE |=> $stable(capEn) && $stable(wdt_q) && $stable(run_q))
		else $error("unmapped write changed state");

endmodule
`default_nettype wire

// file: pccr_cfg.svh
// Register indices, field positions and reset values of the counter/capture registers
`ifndef PCCR_CFG_SVH
`define PCCR_CFG_SVH

`define PCCR_IDX_CNT_LO  8'hf9
`define PCCR_IDX_CNT_HI  8'hfa
`define PCCR_IDX_CAP_LO0 8'hfb
`define PCCR_IDX_CAP_LO1 8'he9
`define PCCR_IDX_CAP_LO2 8'heb
`define PCCR_IDX_CAP_LO3 8'hed
`define PCCR_IDX_CAP_LO4 8'hfd
`define PCCR_IDX_CAP_HI0 8'hfc
`define PCCR_IDX_CAP_HI1 8'hea
`define PCCR_IDX_CAP_HI2 8'hec
`define PCCR_IDX_CAP_HI3 8'hee
`define PCCR_IDX_CAP_HI4 8'hfe
`define PCCR_IDX_CTRL    8'he0
`define PCCR_IDX_STAT    8'he1

`define PCCR_CTRL_WDT_BIT 0
`define PCCR_CTRL_RUN_BIT 1
`define PCCR_STAT_MATCH_LSB 8

`define PCCR_RST_BYTE  8'h00
`define PCCR_RST_WORD  16'h0000
`define PCCR_RST_MODS  5'h00
`define PCCR_NUM_MODS  5

`endif

// file: pccr_pkg.sv
// Types shared by the counter/capture register block
`default_nettype none
package pccr_pkg;

	typedef enum {
		SEL_NONE,
		SEL_CNT_LO,
		SEL_CNT_HI,
		SEL_CAP_LO,
		SEL_CAP_HI,
		SEL_CTRL,
		SEL_STAT
	} pccr_sel_t;

	typedef struct packed {
		logic       wrLow;
		logic       wrHigh;
		logic [7:0] data;
	} pccr_capwr_t;

	typedef struct packed {
		logic       wrLow;
		logic       wrHigh;
		logic       snapLoad;
		logic [7:0] data;
	} pccr_cntwr_t;

endpackage
`default_nettype wire

// file: pccr_counter.sv
// Array counter with high-byte snapshot latch and watchdog write lock
`default_nettype none
`include "pccr_cfg.svh"
module pccr_counter
	import pccr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        runEn,
	input  wire logic        watchdogEnable,
	input  wire pccr_cntwr_t cmd,
	output logic [15:0]      countValue,
	output logic [7:0]       snapshot
);

	logic [15:0] count_q;
	logic [7:0]  snap_q;

	// R4 R14 R15 - locked writes
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= `PCCR_RST_WORD;
		end else if (cmd.wrLow && !watchdogEnable) begin
			count_q <= {count_q[15:8], cmd.data};
		end else if (cmd.wrHigh && !watchdogEnable) begin
			count_q <= {cmd.data, count_q[7:0]};
		end else if (runEn) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// R3 R16 - load on low read only
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			snap_q <= `PCCR_RST_BYTE;
		end else if (cmd.snapLoad) begin
			snap_q <= count_q[15:8];
		end
	end

	assign countValue = count_q;
	assign snapshot   = snap_q;

endmodule
`default_nettype wire

// file: pccr_capture.sv
// One capture/compare module: value bytes, comparator enable, match flag
`default_nettype none
`include "pccr_cfg.svh"
module pccr_capture
	import pccr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire pccr_capwr_t cmd,
	input  wire logic [15:0] countValue,
	output logic [15:0]      value,
	output logic             compEnable,
	output logic             matchOut
);

	logic [15:0] value_q;
	logic        compEn_q;
	logic        match_q;

	// R5 R8 R15 - byte storage
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			value_q <= `PCCR_RST_WORD;
		end else if (cmd.wrLow) begin
			value_q <= {value_q[15:8], cmd.data};
		end else if (cmd.wrHigh) begin
			value_q <= {cmd.data, value_q[7:0]};
		end
	end

	// R7 R10 - write side effects
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			compEn_q <= 1'b0;
		end else if (cmd.wrLow) begin
			compEn_q <= 1'b0;
		end else if (cmd.wrHigh) begin
			compEn_q <= 1'b1;
		end
	end

	// R13 - compare while enabled
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			match_q <= 1'b0;
		end else begin
			match_q <= compEn_q && (countValue == value_q);
		end
	end

	assign value      = value_q;
	assign compEnable = compEn_q;
	assign matchOut   = match_q;

endmodule
`default_nettype wire

// file: pccr_counter_capture_regs_test.sv
// Self-checking bench for the counter/capture register block
`default_nettype none
module pccr_counter_capture_regs_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [4:0]  matchOut;
	logic [4:0]  compEnable;
	logic        watchdogEnable;
	int          errorCnt;
	int          checksDone;
	int          cycleCnt;
	logic [7:0]  capLo [5] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd};
	logic [7:0]  capHi [5] = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe};

	pccr_counter_capture_regs dut_u (
		.clk_sys        (clk_sys),
		.reset_n        (reset_n),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.paddr          (paddr),
		.pwdata         (pwdata),
		.pstrb          (pstrb),
		.prdata         (prdata),
		.pready         (pready),
		.pslverr        (pslverr),
		.matchOut       (matchOut),
		.compEnable     (compEnable),
		.watchdogEnable (watchdogEnable)
	);

	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	task automatic wrapUp();
		$display("errors %0d, checks %0d", errorCnt, checksDone);
		if (errorCnt == 0 && checksDone > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Hang guard, well above the few hundred cycles the scenarios need
	always @(posedge clk_sys) begin
		cycleCnt <= cycleCnt + 1;
		if (cycleCnt == 20000) begin
			errorCnt++;
			$display("ERROR %0t: run timed out", $time);
			wrapUp();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checksDone++;
		if (got !== exp) begin
			errorCnt++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One transfer; request held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] st,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= {24'h000000, wd};
		pstrb   <= st;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Waits as long as needed; the cycle guard ends a hang
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		// One wait state: answer in the second access cycle
		chk(32'(n), 32'd2, "access cycles");
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, idx, d, 4'h1, r, e);
	endtask

	task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, idx, 8'h00, 4'h0, r, e);
		chk(r, {24'h000000, exp}, "read data");
		chk({31'h0, e}, 32'h0, "slave error");
	endtask

	// Enable and match flops land one and two edges after the write
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	task automatic doReset();
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
	endtask

	task automatic resetValues();
		for (int i = 0; i < 5; i++) begin
			rdChk(capLo[i], 8'h00);
			rdChk(capHi[i], 8'h00);
		end
		rdChk(8'hf9, 8'h00);
		rdChk(8'hfa, 8'h00);
		chk({21'h0, matchOut, watchdogEnable, compEnable}, 32'h0, "enables after reset");
	endtask

	task automatic captureMap();
		for (int i = 0; i < 5; i++) begin
			wr(capHi[i], 8'ha0 + 8'(i));
			settle();
			chk({27'h0, compEnable}, 32'h1 << i, "enable after high write");
			wr(capLo[i], 8'h11 + 8'(i));
			settle();
			chk({27'h0, compEnable}, 32'h0, "enable after low write");
			rdChk(capLo[i], 8'h11 + 8'(i));
			rdChk(capHi[i], 8'ha0 + 8'(i));
		end
	endtask

	task automatic snapshot();
		wr(8'hf9, 8'h10);
		wr(8'hfa, 8'h5a);
		rdChk(8'hfa, 8'h00);
		rdChk(8'hf9, 8'h10);
		rdChk(8'hfa, 8'h5a);
		wr(8'hfa, 8'h77);
		rdChk(8'hfa, 8'h5a);
		rdChk(8'hfa, 8'h5a);
		rdChk(8'hf9, 8'h10);
		rdChk(8'hfa, 8'h77);
	endtask

	task automatic watchdogLock();
		wr(8'he0, 8'h01);
		settle();
		chk({31'h0, watchdogEnable}, 32'h1, "watchdog enable");
		rdChk(8'he0, 8'h01);
		wr(8'hf9, 8'h33);
		wr(8'hfa, 8'h44);
		rdChk(8'hf9, 8'h10);
		rdChk(8'hfa, 8'h77);
		wr(8'he0, 8'h00);
		wr(8'hfa, 8'h44);
		rdChk(8'hf9, 8'h10);
		rdChk(8'hfa, 8'h44);
	endtask

	// Run bit set for exactly four edges between two back-to-back control writes
	task automatic counting();
		wr(8'he0, 8'h02);
		wr(8'he0, 8'h00);
		rdChk(8'hf9, 8'h14);
		rdChk(8'hfa, 8'h44);
	endtask

	task automatic refusals();
		logic [31:0] r;
		logic        e;
		apb(1'b0, 8'h00, 8'h00, 4'h0, r, e);
		chk(r, 32'h0, "unmapped read data");
		chk({31'h0, e}, 32'h1, "unmapped error");
		apb(1'b1, 8'h00, 8'h5a, 4'h1, r, e);
		chk({31'h0, e}, 32'h1, "unmapped write error");
		// Strobe off: neither the byte nor the enable may move
		apb(1'b1, capHi[1], 8'h3c, 4'h0, r, e);
		settle();
		chk({27'h0, compEnable}, 32'h0, "enable after masked write");
		rdChk(capHi[1], 8'ha1);
	endtask

	task automatic matchFlag();
		logic [31:0] r;
		logic        e;
		wr(8'hf9, 8'h20);
		wr(8'hfa, 8'h01);
		wr(capLo[0], 8'h20);
		wr(capHi[0], 8'h01);
		settle();
		chk({27'h0, matchOut}, 32'h1, "match on equal value");
		apb(1'b0, 8'he1, 8'h00, 4'h0, r, e);
		chk(r, 32'h0000_0101, "match and enable status");
		chk({31'h0, e}, 32'h0, "status error");
		wr(capLo[0], 8'h20);
		settle();
		chk({27'h0, matchOut}, 32'h0, "match after disable");
	endtask

	initial begin
		reset_n    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 12'h000;
		pwdata     = 32'h00000000;
		pstrb      = 4'h0;
		errorCnt   = 0;
		checksDone = 0;
		cycleCnt   = 0;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		resetValues();
		captureMap();
		snapshot();
		watchdogLock();
		counting();
		refusals();
		matchFlag();
		// Second reset after everything holds data
		doReset();
		resetValues();
		wrapUp();
	end
endmodule
`default_nettype wire
